// [hdl/ugr_get_handler.sv]
`timescale 1ns/10ps
module ugr_get_handler (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	input wire ugr_pkg::ugr_setup_t i_setup,
	input wire logic i_bus_reset,
	input wire logic i_set_addr,
	input wire logic i_addr_nonzero,
	input wire logic i_set_cfg,
	input wire logic [7:0] i_cfg_value,
	input wire logic i_set_if,
	input wire logic [1:0] i_if_num,
	input wire logic [7:0] i_if_alt,
	input wire ugr_pkg::ugr_feature_t i_feature,
	input wire logic [ugr_pkg::NUM_EP-1:0] i_hw_halt,
	input wire logic i_tx_ready,
	output ugr_pkg::ugr_tx_t o_tx,
	output ugr_pkg::ugr_resp_t o_resp,
	output logic [ugr_pkg::NUM_EP-1:0] o_ep_stall,
	output logic [ugr_pkg::NUM_EP-1:0] o_toggle_reset,
	output ugr_pkg::ugr_dev_state_t o_dev_state
);

	// ==========================================================
	// State
	typedef struct packed {
		ugr_pkg::ugr_dev_state_t dev_state;
		logic [7:0] cfg;
		logic remote_wake;
		logic ctrl_halt;
		logic [ugr_pkg::NUM_EP-1:0] halt;
		logic [ugr_pkg::NUM_IF-1:0][7:0] alt;
		logic self_pwr;
		logic hs_cap;
		logic [7:0] mps;
		logic [7:0] present;
		logic [3:0] if_count;
		logic [7:0] ep_valid;
		logic [8:0] ptr;
		logic [31:0] rdata;
		ugr_pkg::ugr_resp_state_t fsm;
		logic from_rom;
		logic [8:0] addr;
		logic [15:0] remain;
		logic [15:0] imm;
		logic zlp_pend;
		ugr_pkg::ugr_tx_t tx;
		ugr_pkg::ugr_resp_t resp;
		logic [ugr_pkg::NUM_EP-1:0] tog_rst;
	} ugr_core_t;

	ugr_core_t q, d;
	logic [7:0] mem [0:ugr_pkg::MEM_BYTES-1];
	logic mem_we;

	// Endpoint field of the index word: valid form, then {direction, number}.
	function automatic logic [3:0] ep_slot(input logic [15:0] idx);
		ep_slot = {(idx[15:8] == 8'h00) && (idx[6:2] == 5'h00), idx[7], idx[1:0]};
	endfunction

	// ==========================================================
	// Decode scratch
	logic std_in, is_ours, accept, err, use_rom;
	logic [2:0] slot, epi;
	logic [3:0] eps;
	logic [8:0] base;
	logic [15:0] dlen, slen, imm_w, clip;
	logic [7:0] dtype, didx;
	logic ep_exists;

	always_comb begin
		d = q;
		mem_we = 1'b0;
		err = 1'b0;
		use_rom = 1'b0;
		slot = ugr_pkg::SLOT_DEV;
		imm_w = 16'h0000;
		slen = 16'h0000;
		dlen = 16'h0000;
		clip = 16'h0000;
		d.resp = '0;
		d.tog_rst = '0;
		d.rdata = 32'h0000_0000;
		// ======================================================
		// Register bus
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				ugr_pkg::REG_CTRL: d.rdata = {16'h0000, q.mps, 5'h00, q.ctrl_halt, q.hs_cap, q.self_pwr};
				ugr_pkg::REG_PRESENT: d.rdata = {24'h000000, q.present};
				ugr_pkg::REG_TOPO: d.rdata = {16'h0000, q.ep_valid, 4'h0, q.if_count};
				ugr_pkg::REG_PTR: d.rdata = {23'h000000, q.ptr};
				ugr_pkg::REG_STATUS: begin
					d.rdata = {8'h00, q.halt, q.cfg, 4'h0, q.ctrl_halt, q.remote_wake, q.dev_state};
				end
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				ugr_pkg::REG_CTRL: begin
					d.self_pwr = i_reg_wdata[ugr_pkg::CTRL_SELF_PWR];
					d.hs_cap = i_reg_wdata[ugr_pkg::CTRL_HS];
					d.ctrl_halt = i_reg_wdata[ugr_pkg::CTRL_HALT];
					d.mps = i_reg_wdata[ugr_pkg::CTRL_MPS_LSB +: 8];
				end
				ugr_pkg::REG_PRESENT: d.present = i_reg_wdata[7:0];
				ugr_pkg::REG_TOPO: begin
					d.if_count = i_reg_wdata[3:0];
					d.ep_valid = i_reg_wdata[ugr_pkg::TOPO_EP_LSB +: 8];
				end
				ugr_pkg::REG_PTR: d.ptr = i_reg_wdata[8:0];
				ugr_pkg::REG_DATA: begin
					mem_we = 1'b1;
					d.ptr = q.ptr + 9'h001;
				end
				default: d.ptr = q.ptr;
			endcase
		end
		// ======================================================
		// Device state and feature bookkeeping
		// state register
		if (i_set_addr && q.dev_state != ugr_pkg::DS_CONFIGURED) begin
			d.dev_state = i_addr_nonzero ? ugr_pkg::DS_ADDRESS : ugr_pkg::DS_DEFAULT;
		end
		if (i_set_cfg && q.dev_state != ugr_pkg::DS_DEFAULT) begin
			d.cfg = i_cfg_value;
			d.dev_state = (i_cfg_value == 8'h00) ? ugr_pkg::DS_ADDRESS : ugr_pkg::DS_CONFIGURED;
			d.alt = '0;
		end
		if (i_set_if) begin
			d.alt[i_if_num] = i_if_alt;
		end
		if (i_set_cfg || i_set_if) begin
			d.halt = '0;
		end
		// A clear and a set arriving together resolve to set, applied after the other clears; a bus reset is applied later still and wins.
		eps = ep_slot(i_feature.index);
		epi = eps[2:0];
		if (i_feature.valid) begin
			if (i_feature.recipient == ugr_pkg::RCP_DEV &&
				i_feature.selector == ugr_pkg::FEAT_REMOTE_WAKE) begin
				d.remote_wake = i_feature.set;
			end
			if (i_feature.recipient == ugr_pkg::RCP_EP &&
				i_feature.selector == ugr_pkg::FEAT_EP_HALT && eps[3]) begin
				if (epi[1:0] == 2'b00) begin
					d.ctrl_halt = i_feature.set || (i_reg_wr && i_reg_addr == ugr_pkg::REG_CTRL &&
						i_reg_wdata[ugr_pkg::CTRL_HALT]);
				end else begin
					d.halt[epi] = i_feature.set;
				end
				d.tog_rst[epi] = !i_feature.set;
			end
		end
		// ======================================================
		// Request decode
		std_in = i_setup.req_type[7] && i_setup.req_type[6:5] == ugr_pkg::TYPE_STD;
		is_ours = std_in && (i_setup.request == ugr_pkg::REQ_GET_STATUS ||
			i_setup.request == ugr_pkg::REQ_GET_DESC ||
			i_setup.request == ugr_pkg::REQ_GET_CFG ||
			i_setup.request == ugr_pkg::REQ_GET_IF);
		accept = i_setup.valid && is_ours;
		dtype = i_setup.value[15:8];
		didx = i_setup.value[7:0];
		eps = ep_slot(i_setup.index);
		ep_exists = eps[3] && (eps[1:0] == 2'b00 ||
			(q.dev_state == ugr_pkg::DS_CONFIGURED && q.ep_valid[eps[2:0]]));
		unique case (i_setup.request)
			ugr_pkg::REQ_GET_CFG: begin
				imm_w = {8'h00, q.cfg};
				slen = 16'h0001;
				err = q.dev_state == ugr_pkg::DS_DEFAULT;
			end
			ugr_pkg::REQ_GET_IF: begin
				imm_w = {8'h00, q.alt[i_setup.index[1:0]]};
				slen = 16'h0001;
				err = q.dev_state != ugr_pkg::DS_CONFIGURED ||
					i_setup.index >= {12'h000, q.if_count};
			end
			ugr_pkg::REQ_GET_STATUS: begin
				slen = 16'h0002;
				unique case (i_setup.req_type[4:0])
					ugr_pkg::RCP_DEV: begin
						imm_w[ugr_pkg::STS_SELF_PWR] = q.self_pwr;
						imm_w[ugr_pkg::STS_REMOTE_WAKE] = q.remote_wake;
						err = q.dev_state == ugr_pkg::DS_DEFAULT;
					end
					ugr_pkg::RCP_IF: begin
						imm_w = 16'h0000;
						err = q.dev_state != ugr_pkg::DS_CONFIGURED ||
							i_setup.index >= {12'h000, q.if_count};
					end
					ugr_pkg::RCP_EP: begin
						imm_w[ugr_pkg::STS_HALT] = (eps[1:0] == 2'b00) ? q.ctrl_halt :
							(q.halt[eps[2:0]] || i_hw_halt[eps[2:0]]);
						err = q.dev_state == ugr_pkg::DS_DEFAULT || !ep_exists;
					end
					default: err = 1'b1;
				endcase
			end
			default: begin
				use_rom = 1'b1;
				unique case (dtype)
					ugr_pkg::DT_DEVICE: err = didx != 8'h00;
					ugr_pkg::DT_QUAL: begin
						slot = ugr_pkg::SLOT_QUAL;
						err = didx != 8'h00 || !q.hs_cap;
					end
					ugr_pkg::DT_CONFIG: begin
						slot = ugr_pkg::SLOT_CFG0 + didx[2:0];
						err = didx >= 8'(ugr_pkg::NUM_CFG);
					end
					ugr_pkg::DT_OSC: begin
						slot = ugr_pkg::SLOT_OSC;
						err = didx != 8'h00 || !q.hs_cap;
					end
					ugr_pkg::DT_STRING: begin
						slot = ugr_pkg::SLOT_STR0 + didx[2:0];
						err = didx >= 8'(ugr_pkg::NUM_STR);
					end
					default: err = 1'b1;
				endcase
				err = err || !q.present[slot];
			end
		endcase
		base = {slot, 6'h00};
		if (use_rom) begin
			slen = (dtype == ugr_pkg::DT_CONFIG || dtype == ugr_pkg::DT_OSC) ?
				{mem[base + ugr_pkg::TOTAL_LEN_HI], mem[base + ugr_pkg::TOTAL_LEN_LO]} :
				{8'h00, mem[base]};
			if (slen > ugr_pkg::SLOT_BYTES) begin
				slen = ugr_pkg::SLOT_BYTES;
			end
		end
		if (q.ctrl_halt && i_setup.request != ugr_pkg::REQ_GET_STATUS) begin
			err = 1'b1;
		end
		dlen = (slen > i_setup.length) ? i_setup.length : slen;
		// ======================================================
		// Responder
		unique case (q.fsm)
			ugr_pkg::RS_IDLE: d.fsm = ugr_pkg::RS_IDLE;
			ugr_pkg::RS_SEND: begin
				if (q.tx.valid && i_tx_ready) begin
					if (q.remain == 16'h0000) begin
						d.tx = '0;
						d.fsm = ugr_pkg::RS_DONE;
					end else begin
						d.tx.data = q.from_rom ? mem[q.addr] : q.imm[7:0];
						d.tx.last = q.remain == 16'h0001;
						d.addr = q.addr + 9'h001;
						d.imm = {8'h00, q.imm[15:8]};
						d.remain = q.remain - 16'h0001;
					end
				end
			end
			ugr_pkg::RS_DONE: begin
				d.resp.done = 1'b1;
				d.resp.zlp = q.zlp_pend;
				d.fsm = ugr_pkg::RS_IDLE;
			end
			ugr_pkg::RS_STALL: begin
				d.resp.stall = 1'b1;
				d.resp.done = 1'b1;
				d.fsm = ugr_pkg::RS_IDLE;
			end
		endcase
		// An accepted standard GET setup restarts the responder unless a bus reset comes with it, as the host has abandoned the old one.
		// any state
		if (accept) begin
			d.tx = '0;
			d.from_rom = use_rom;
			clip = dlen - 16'h0001;
			d.zlp_pend = slen < i_setup.length && q.mps != 8'h00 &&
				(dlen % {8'h00, q.mps}) == 16'h0000;
			if (err) begin
				d.fsm = ugr_pkg::RS_STALL;
			end else if (dlen == 16'h0000) begin
				d.fsm = ugr_pkg::RS_DONE;
			end else begin
				d.fsm = ugr_pkg::RS_SEND;
				d.tx.valid = 1'b1;
				d.tx.data = use_rom ? mem[base] : imm_w[7:0];
				d.tx.last = dlen == 16'h0001;
				d.addr = base + 9'h001;
				d.imm = {8'h00, imm_w[15:8]};
				d.remain = clip;
			end
		end
		if (i_bus_reset) begin
			d.dev_state = ugr_pkg::DS_DEFAULT;
			d.cfg = 8'h00;
			d.remote_wake = 1'b0;
			d.ctrl_halt = 1'b0;
			d.halt = '0;
			d.alt = '0;
			d.fsm = ugr_pkg::RS_IDLE;
			d.tx = '0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			q <= '0;
			q.dev_state <= ugr_pkg::DS_DEFAULT;
			q.fsm <= ugr_pkg::RS_IDLE;
			q.mps <= ugr_pkg::MPS_RESET;
			q.present <= ugr_pkg::PRESENT_RESET;
			q.if_count <= ugr_pkg::IF_COUNT_RESET;
			q.ep_valid <= ugr_pkg::EP_VALID_RESET;
		end else begin
			q <= d;
		end
	end

	// The store has no reset; software loads it before enabling the pull-up.
	always_ff @(posedge i_clk_sys) begin
		if (mem_we) begin
			mem[q.ptr] <= i_reg_wdata[7:0];
		end
	end

	assign o_reg_rdata = q.rdata;
	assign o_tx = q.tx;
	assign o_resp = q.resp;
	assign o_toggle_reset = q.tog_rst;
	assign o_dev_state = q.dev_state;
	assign o_ep_stall = q.halt | i_hw_halt;

	// ==========================================================
	// Checks
	logic [15:0] sent_q, wlen_q;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || accept) begin
			sent_q <= 16'h0000;
			wlen_q <= accept ? i_setup.length : 16'h0000;
		end else if (q.tx.valid && i_tx_ready) begin
			sent_q <= sent_q + 16'h0001;
		end
	end

	property p_cfg_byte;
		@(posedge i_clk_sys) disable iff (i_reset)
		(accept && !i_bus_reset && i_setup.request == ugr_pkg::REQ_GET_CFG && !q.ctrl_halt &&
			q.dev_state == ugr_pkg::DS_CONFIGURED && i_setup.length == 16'h0001)
		|=> (o_tx.valid && o_tx.last && o_tx.data == $past(q.cfg));
	endproperty
	a_cfg_byte: assert property (p_cfg_byte) else $error("config byte wrong");

	property p_no_excess;
		@(posedge i_clk_sys) disable iff (i_reset)
		sent_q <= wlen_q;
	endproperty
	a_no_excess: assert property (p_no_excess) else $error("sent beyond length");

	property p_bad_desc;
		@(posedge i_clk_sys) disable iff (i_reset || i_bus_reset)
		(accept && i_setup.request == ugr_pkg::REQ_GET_DESC && dtype == 8'h05)
		|=> (q.fsm == ugr_pkg::RS_STALL) ##1 (o_resp.stall && o_resp.done);
	endproperty
	a_bad_desc: assert property (p_bad_desc) else $error("missing descriptor not stalled");

	property p_if_addr;
		@(posedge i_clk_sys) disable iff (i_reset || i_bus_reset)
		(accept && i_setup.request == ugr_pkg::REQ_GET_IF && q.dev_state == ugr_pkg::DS_ADDRESS)
		|=> ##1 o_resp.stall;
	endproperty
	a_if_addr: assert property (p_if_addr) else $error("interface in address not stalled");

	property p_sts_addr;
		@(posedge i_clk_sys) disable iff (i_reset || i_bus_reset)
		(accept && i_setup.request == ugr_pkg::REQ_GET_STATUS &&
			i_setup.req_type[4:0] == ugr_pkg::RCP_IF && q.dev_state == ugr_pkg::DS_ADDRESS)
		|=> !o_tx.valid ##1 o_resp.stall;
	endproperty
	a_sts_addr: assert property (p_sts_addr) else $error("status error missed");

	property p_wake_reset;
		@(posedge i_clk_sys) disable iff (i_reset)
		i_bus_reset |=> !q.remote_wake && o_dev_state == ugr_pkg::DS_DEFAULT;
	endproperty
	a_wake_reset: assert property (p_wake_reset) else $error("wakeup survives reset");

	property p_toggle;
		@(posedge i_clk_sys) disable iff (i_reset)
		(i_feature.valid && !i_feature.set && i_feature.recipient == ugr_pkg::RCP_EP &&
			i_feature.selector == ugr_pkg::FEAT_EP_HALT &&
			ep_slot(i_feature.index) == 4'h9)
		|=> o_toggle_reset[1] && !o_ep_stall[1] || $past(i_hw_halt[1]) || i_hw_halt[1];
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle not reset");

	property p_halt_clear;
		@(posedge i_clk_sys) disable iff (i_reset)
		((i_set_cfg || i_set_if) && !i_feature.valid) |=> (q.halt == '0);
	endproperty
	a_halt_clear: assert property (p_halt_clear) else $error("halt kept after set");

	property p_err_no_halt;
		@(posedge i_clk_sys) disable iff (i_reset)
		(q.fsm == ugr_pkg::RS_STALL && !q.ctrl_halt && !i_feature.valid && !i_reg_wr)
		|=> !q.ctrl_halt;
	endproperty
	a_err_no_halt: assert property (p_err_no_halt) else $error("error set pipe halt");

endmodule

// [include/ugr_pkg.sv]
package ugr_pkg;

	// ==========================================================
	// Sizes and descriptor store layout
	localparam int NUM_IF = 4;
	localparam int NUM_EP = 8;
	localparam int NUM_CFG = 2;
	localparam int NUM_STR = 3;
	localparam int MEM_BYTES = 512;
	localparam int SLOT_SHIFT = 6;
	localparam logic [15:0] SLOT_BYTES = 16'h0040;
	localparam logic [2:0] SLOT_DEV = 3'h0;
	localparam logic [2:0] SLOT_QUAL = 3'h1;
	localparam logic [2:0] SLOT_CFG0 = 3'h2;
	localparam logic [2:0] SLOT_OSC = 3'h4;
	localparam logic [2:0] SLOT_STR0 = 3'h5;
	localparam logic [8:0] TOTAL_LEN_LO = 9'h002;
	localparam logic [8:0] TOTAL_LEN_HI = 9'h003;

	// ==========================================================
	// Request fields and codes
	localparam logic [7:0] REQ_GET_STATUS = 8'h00;
	localparam logic [7:0] REQ_GET_DESC = 8'h06;
	localparam logic [7:0] REQ_GET_CFG = 8'h08;
	localparam logic [7:0] REQ_GET_IF = 8'h0a;
	localparam logic [7:0] DT_DEVICE = 8'h01;
	localparam logic [7:0] DT_CONFIG = 8'h02;
	localparam logic [7:0] DT_STRING = 8'h03;
	localparam logic [7:0] DT_QUAL = 8'h06;
	localparam logic [7:0] DT_OSC = 8'h07;
	localparam logic [15:0] FEAT_EP_HALT = 16'h0000;
	localparam logic [15:0] FEAT_REMOTE_WAKE = 16'h0001;
	localparam logic [4:0] RCP_DEV = 5'h00;
	localparam logic [4:0] RCP_IF = 5'h01;
	localparam logic [4:0] RCP_EP = 5'h02;
	localparam logic [1:0] TYPE_STD = 2'h0;
	localparam int STS_SELF_PWR = 0;
	localparam int STS_REMOTE_WAKE = 1;
	localparam int STS_HALT = 0;

	// ==========================================================
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PRESENT = 8'h04;
	localparam logic [7:0] REG_TOPO = 8'h08;
	localparam logic [7:0] REG_PTR = 8'h0c;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam int CTRL_SELF_PWR = 0;
	localparam int CTRL_HS = 1;
	localparam int CTRL_HALT = 2;
	localparam int CTRL_MPS_LSB = 8;
	localparam int TOPO_EP_LSB = 8;
	localparam logic [7:0] MPS_RESET = 8'h40;
	localparam logic [7:0] PRESENT_RESET = 8'h05;
	localparam logic [3:0] IF_COUNT_RESET = 4'h1;
	localparam logic [7:0] EP_VALID_RESET = 8'h00;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		DS_DEFAULT = 2'b00,
		DS_ADDRESS = 2'b01,
		DS_CONFIGURED = 2'b11
	} ugr_dev_state_t;

	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_SEND = 2'b01,
		RS_DONE = 2'b11,
		RS_STALL = 2'b10
	} ugr_resp_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] req_type;
		logic [7:0] request;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} ugr_setup_t;

	typedef struct packed {
		logic valid;
		logic set;
		logic [4:0] recipient;
		logic [15:0] selector;
		logic [15:0] index;
	} ugr_feature_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} ugr_tx_t;

	typedef struct packed {
		logic done;
		logic stall;
		logic zlp;
	} ugr_resp_t;

endpackage

// [tb/ugr_host_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Host side of the default control pipe.
module ugr_host_model (
	input wire logic i_clk_sys,
	input wire logic i_go,
	input wire logic i_slow,
	input wire ugr_pkg::ugr_setup_t i_req,
	output ugr_pkg::ugr_setup_t o_setup,
	output logic o_tx_ready
);
	initial o_setup = '0;
	initial o_tx_ready = 1'b0;
	// A slow host drops ready at random, so every byte must stand until taken.
	always @(posedge i_clk_sys) begin
		o_setup <= i_req;
		o_setup.valid <= i_go;
		o_tx_ready <= i_slow ? 1'($urandom_range(1)) : 1'b1;
	end
endmodule

// [tb/tb_usb_std_get_request_handler.sv]
`timescale 1ns/10ps
module tb_usb_std_get_request_handler;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic b_rst = 1'b0;
	logic s_addr = 1'b0;
	logic s_cfg = 1'b0;
	logic s_if = 1'b0;
	logic rdy;
	logic [7:0] addr = '0;
	logic [7:0] cfg_v = '0;
	logic [7:0] hw = '0;
	logic [7:0] stl;
	logic [7:0] tgl;
	logic [7:0] d[8];
	logic [7:0] bad[4] = '{ugr_pkg::DT_STRING, ugr_pkg::DT_QUAL, ugr_pkg::DT_OSC, 8'h05};
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic [9:0] q[$];
	ugr_pkg::ugr_setup_t rq = '0;
	ugr_pkg::ugr_setup_t setup;
	ugr_pkg::ugr_feature_t ft = '0;
	ugr_pkg::ugr_feature_t ff;
	ugr_pkg::ugr_tx_t tx;
	ugr_pkg::ugr_resp_t rs;
	ugr_pkg::ugr_dev_state_t st;
	int num_errors = 0;
	int check_count = 0;
	int n_done = 0;
	int cyc = 0;

	always #5 clk = ~clk;

	ugr_host_model u_host (.i_clk_sys(clk), .i_go(go), .i_slow(slow), .i_req(rq),
		.o_setup(setup), .o_tx_ready(rdy));
	ugr_get_handler u_dut (.i_clk_sys(clk), .i_reset(rst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
		.i_setup(setup), .i_bus_reset(b_rst), .i_set_addr(s_addr), .i_addr_nonzero(|cfg_v),
		.i_set_cfg(s_cfg), .i_cfg_value(cfg_v), .i_set_if(s_if), .i_if_num(2'h0),
		.i_if_alt(cfg_v), .i_feature(ft), .i_hw_halt(hw), .i_tx_ready(rdy), .o_tx(tx),
		.o_resp(rs), .o_ep_stall(stl), .o_toggle_reset(tgl), .o_dev_state(st));

	// ==========================================================
	// Checking and closing.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic take(input logic [9:0] s);
		if (q.size() == 0) begin
			chk("unexpected", s, 32'hffffffff);
		end else begin
			chk("reply", s, q.pop_front());
		end
	endtask
	// The watcher samples at the edge, so it sees values launched one edge before.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!rst && rdy && tx.valid === 1'b1) begin
			take({1'b0, tx.last, tx.data});
		end
		if (!rst && rs.done === 1'b1) begin
			take({1'b1, rs.zlp, 7'h00, rs.stall});
			n_done++;
		end
		if (cyc == 30000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ==========================================================
	// Drivers.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("rdata", rdata, v);
	endtask
	task automatic ev(input int k, input logic [7:0] v);
		@(posedge clk);
		cfg_v <= v;
		case (k)
			0: b_rst <= 1'b1;
			1: s_addr <= 1'b1;
			2: s_cfg <= 1'b1;
			3: s_if <= 1'b1;
			default: ft <= ff;
		endcase
		@(posedge clk);
		{b_rst, s_addr, s_cfg, s_if, ft.valid} <= '0;
		#1;
	endtask
	task automatic feat(input logic s, input logic [4:0] r, input logic [15:0] x);
		ff = '{1'b1, s, r, (r == ugr_pkg::RCP_EP) ? ugr_pkg::FEAT_EP_HALT :
			ugr_pkg::FEAT_REMOTE_WAKE, x};
		ev(4, 8'h00);
	endtask
	task automatic fin(input logic z, input logic s);
		q.push_back({1'b1, z, 7'h00, s});
	endtask
	task automatic req(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
			input logic [15:0] x, input logic [15:0] n);
		int k;
		k = n_done;
		@(posedge clk);
		go <= 1'b1;
		rq <= '{1'b1, t, c, v, x, n};
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 300 && n_done == k; i++) begin
			@(posedge clk);
			#1;
		end
		chk("left", q.size(), 0);
	endtask
	task automatic gd(input logic [7:0] t, input logic [7:0] i, input logic [15:0] n,
			input int o, input int m, input logic z, input logic s);
		for (int j = 0; j < m; j++) q.push_back({1'b0, 1'(j == m - 1), d[o+j]});
		fin(z, s);
		req(8'h80, ugr_pkg::REQ_GET_DESC, {t, i}, 16'h0000, n);
	endtask
	task automatic gs(input logic [7:0] t, input logic [15:0] x, input logic [15:0] w,
			input logic s);
		if (!s) begin
			q.push_back({2'b00, w[7:0]});
			q.push_back({2'b01, w[15:8]});
		end
		fin(1'b0, s);
		req(t, ugr_pkg::REQ_GET_STATUS, 16'h0000, x, 16'h0002);
	endtask
	task automatic g1(input logic [7:0] c, input logic [15:0] x, input logic [7:0] w,
			input logic s);
		if (!s) q.push_back({2'b01, w});
		fin(1'b0, s);
		req((c == ugr_pkg::REQ_GET_IF) ? 8'h81 : 8'h80, c, 16'h0000, x, 16'h0001);
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		void'($urandom(28));
		for (int i = 0; i < 8; i++) d[i] = 8'($urandom);
		d[0] = 8'h04;
		d[6] = 8'h0c;
		d[7] = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("state", st, ugr_pkg::DS_DEFAULT);
		rd(ugr_pkg::REG_CTRL, 32'h00004000);
		rd(ugr_pkg::REG_TOPO, 32'h00000001);
		rd(8'hfc, 32'h00000000);
		wr(ugr_pkg::REG_CTRL, 32'h00000401);
		wr(ugr_pkg::REG_TOPO, 32'h00000201);
		wr(ugr_pkg::REG_PTR, 32'h00000000);
		for (int i = 0; i < 4; i++) wr(ugr_pkg::REG_DATA, {24'h0, d[i]});
		wr(ugr_pkg::REG_PTR, 32'h00000080);
		for (int i = 4; i < 8; i++) wr(ugr_pkg::REG_DATA, {24'h0, d[i]});
		rd(ugr_pkg::REG_PTR, 32'h00000084);
		gd(ugr_pkg::DT_DEVICE, 8'h00, 16'h0002, 0, 2, 1'b0, 1'b0);
		gs(8'h80, 16'h0000, 16'h0000, 1'b1);
		ev(1, 8'h01);
		chk("state", st, ugr_pkg::DS_ADDRESS);
		ev(1, 8'h00);
		chk("state", st, ugr_pkg::DS_DEFAULT);
		ev(1, 8'h01);
		chk("state", st, ugr_pkg::DS_ADDRESS);
		g1(ugr_pkg::REQ_GET_CFG, 16'h0000, 8'h00, 1'b0);
		g1(ugr_pkg::REQ_GET_IF, 16'h0000, 8'h00, 1'b1);
		gs(8'h81, 16'h0000, 16'h0000, 1'b1);
		gs(8'h82, 16'h0000, 16'h0000, 1'b0);
		gs(8'h82, 16'h0001, 16'h0000, 1'b1);
		gs(8'h80, 16'h0000, 16'h0001, 1'b0);
		@(posedge clk);
		slow <= 1'b1;
		gd(ugr_pkg::DT_DEVICE, 8'h00, 16'h0008, 0, 4, 1'b1, 1'b0);
		gd(ugr_pkg::DT_CONFIG, 8'h00, 16'h0004, 4, 4, 1'b0, 1'b0);
		gd(ugr_pkg::DT_CONFIG, 8'h01, 16'h0004, 0, 0, 1'b0, 1'b1);
		foreach (bad[i]) gd(bad[i], 8'h00, 16'h0008, 0, 0, 1'b0, 1'b1);
		ev(2, 8'h05);
		g1(ugr_pkg::REQ_GET_CFG, 16'h0000, 8'h05, 1'b0);
		ev(3, 8'h03);
		g1(ugr_pkg::REQ_GET_IF, 16'h0000, 8'h03, 1'b0);
		g1(ugr_pkg::REQ_GET_IF, 16'h0001, 8'h00, 1'b1);
		gs(8'h81, 16'h0000, 16'h0000, 1'b0);
		gs(8'h81, 16'h0002, 16'h0000, 1'b1);
		feat(1'b1, ugr_pkg::RCP_DEV, 16'h0000);
		gs(8'h80, 16'h0000, 16'h0003, 1'b0);
		feat(1'b1, ugr_pkg::RCP_EP, 16'h0001);
		chk("stall", stl, 8'h02);
		gs(8'h82, 16'h0001, 16'h0001, 1'b0);
		feat(1'b0, ugr_pkg::RCP_EP, 16'h0001);
		chk("toggle", tgl, 8'h02);
		chk("stall", stl, 8'h00);
		feat(1'b1, ugr_pkg::RCP_EP, 16'h0001);
		ev(3, 8'h00);
		chk("stall", stl, 8'h00);
		@(posedge clk);
		hw <= 8'h04;
		@(posedge clk);
		#1;
		chk("stall", stl, 8'h04);
		@(posedge clk);
		hw <= 8'h00;
		rd(ugr_pkg::REG_STATUS, 32'h00000507);
		wr(ugr_pkg::REG_CTRL, 32'h00000405);
		g1(ugr_pkg::REQ_GET_CFG, 16'h0000, 8'h00, 1'b1);
		gs(8'h82, 16'h0000, 16'h0001, 1'b0);
		wr(ugr_pkg::REG_CTRL, 32'h00000401);
		ev(0, 8'h00);
		chk("state", st, ugr_pkg::DS_DEFAULT);
		rd(ugr_pkg::REG_STATUS, 32'h00000000);
		end_of_test();
	end
endmodule
